// ===== logic/vip_pkg.sv
// Purpose: Constants for the vectored interrupt prioritizer.
// Assumes: Registers sit on AXI4-Lite, one byte per aligned word.
// Notes:   Register numbers are indices; the byte address is 4x the index.
//
// How it works
// (R1) Reset low clears state, no request out
// (R2) Host configures unit before enabling it
// (R3) Vector low nibble encodes requesting position
// (R4) Host acknowledges by reading master vector
// (R5) Single unit: host keeps bias top bit zero
// (R6) Cascaded position yields negative cascade index
// (R7) Up to sixteen cascaded units, 256 sources
// (R8) Host leaves master position zero uncascaded
// (R9) Status-decoded select needs low address zeros
// (R10) Select decoding includes address bit eight; the code takes 7-bit addresses and decodes only bits 6:2
// (R11) Cascaded unit gives sixteen unsigned vectors
// (R12) Master return read repeats negative cascade index
// (R13) Cascaded return read ends service, byte ignored
// (R14) Return read lets pending requests re-prioritize
// (R15) Pending pair writes set or clear bits
// (R16) Mask bit blocks hardware and software sources
// (R17) Hardware sources: counter outputs and pins
// (R18) Freeze stops hardware setting pending bits
// (R19) Request only when unmasked and outranks service
// (R20) Acknowledge clears pending, sets in-service
// (R21) In-service holds until its return read
// (R22) In-service keeps request off unless outranked
// (R23) Vector: bias or ones nibble, position nibble
// (R24) Every vector register read is ack or return
// (R25) Position zero highest, fifteen lowest
// (R26) Status input tells ack from return read
package vip_pkg;
	// =========================================================
	// Register indices
	localparam logic [4:0] IDX_HW_VECTOR = 5'h00;
	localparam logic [4:0] IDX_BIAS      = 5'h01;
	localparam logic [4:0] IDX_PEND_L    = 5'h06;
	localparam logic [4:0] IDX_PEND_H    = 5'h07;
	localparam logic [4:0] IDX_IN_SERVICE_BITS_L    = 5'h08;
	localparam logic [4:0] IDX_IN_SERVICE_BITS_H    = 5'h09;
	localparam logic [4:0] IDX_MASK_L    = 5'h0a;
	localparam logic [4:0] IDX_MASK_H    = 5'h0b;
	localparam logic [4:0] IDX_CASC_L    = 5'h0c;
	localparam logic [4:0] IDX_CASC_H    = 5'h0d;
	localparam logic [4:0] IDX_MODE      = 5'h10;
	localparam int         ADDR_LSB      = 2;

	// =========================================================
	// Mode control fields
	localparam int MODE_FREEZE  = 0;
	localparam int MODE_ENABLE  = 1;
	localparam int MODE_CASCADE = 2;

	// =========================================================
	// Values after reset and vector coding
	localparam logic [15:0] RST_MASK    = 16'hffff;
	localparam logic [7:0]  RST_MODE    = 8'h00;
	localparam logic [3:0]  RST_BIAS    = 4'h0;
	localparam logic [3:0]  CASC_NIBBLE = 4'hf;

	// =========================================================
	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : vip_pkg

// ===== logic/prio_if.sv
// Purpose: Carries a request vector to a priority finder and back.
// Assumes: Lowest index is the highest priority.
// Notes:   One instance per vector to be ranked.
`timescale 1ns/100ps
interface prio_if;
	logic [15:0] bits;
	logic        found;
	logic [3:0]  index;

	modport enc  (input bits, output found, output index);
	modport user (output bits, input found, input index);
endinterface : prio_if

// ===== logic/prio_find.sv
// Purpose: Finds the highest-priority set bit of a 16-bit vector.
// Assumes: Fixed order, position 0 first.
// Notes:   Purely combinational.
`timescale 1ns/100ps
module prio_find (
	prio_if.enc p
);
	// =========================================================
	// Scan from lowest priority up so position 0 wins
	always_comb begin
		p.found = 1'b0;
		p.index = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (p.bits[i]) begin
				p.found = 1'b1;
				p.index = 4'(i); // see (R25)
			end
		end
	end
endmodule : prio_find

// ===== logic/vip_top.sv
// Purpose: Sixteen-position vectored interrupt prioritizer.
// Assumes: AXI4-Lite slave; byte registers in low data bits.
// Notes:   Reading the vector register changes state.
`timescale 1ns/100ps
module vip_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [6:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [6:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	input  wire logic        return_status,
	input  wire logic [15:0] ext_irq,
	input  wire logic [15:0] counter_irq,
	output logic             irq_n
);
	// =========================================================
	// State
	logic [15:0] pending_bits_ff;
	logic [15:0] in_service_bits_ff;
	logic [15:0] position_mask_ff;
	logic [15:0] cascade_position_list_ff;
	logic [3:0]  bias_nibble_ff;
	logic [7:0]  mode_control_reg_ff;
	logic        irq_n_ff;
	logic        aw_held_ff;
	logic [6:0]  aw_addr_ff;
	logic        w_held_ff;
	logic [7:0]  w_byte_ff;
	logic        w_lane_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [7:0]  rdata_ff;
	logic [1:0]  rresp_ff;

	logic [15:0] hw_sources;
	logic [15:0] eligible;
	logic        freeze_pending;
	logic        unit_enable;
	logic        cascaded_role;
	logic        aw_have;
	logic        w_have;
	logic        do_write;
	logic [6:0]  wr_addr;
	logic [7:0]  wr_byte;
	logic        wr_lane;
	logic [4:0]  wr_idx;
	logic [4:0]  rd_idx;
	logic        rd_take;
	logic        ack_cycle;
	logic        return_cycle;
	logic        irq_cond;
	logic [7:0]  ack_vector;
	logic [7:0]  ret_vector;
	logic [15:0] nxt_pending;
	logic [15:0] nxt_in_service;

	prio_if pend_p ();
	prio_if serv_p ();

	prio_find u_pend_find (.p(pend_p));
	prio_find u_serv_find (.p(serv_p));

	// =========================================================
	// Sources and ranking
	assign hw_sources     = ext_irq | counter_irq; // see (R17)
	assign eligible       = pending_bits_ff & ~position_mask_ff; // see (R16)
	assign pend_p.bits    = eligible;
	assign serv_p.bits    = in_service_bits_ff;
	assign freeze_pending = mode_control_reg_ff[vip_pkg::MODE_FREEZE];
	assign unit_enable    = mode_control_reg_ff[vip_pkg::MODE_ENABLE]; // see (R2)
	assign cascaded_role  = mode_control_reg_ff[vip_pkg::MODE_CASCADE]; // see (R11)

	// Request outranks everything in service
	assign irq_cond = unit_enable && pend_p.found
		&& (!serv_p.found || pend_p.index < serv_p.index); // see (R19) (R22)

	// =========================================================
	// Vector coding: ones nibble for a cascaded master position
	always_comb begin
		ack_vector = {bias_nibble_ff, pend_p.index}; // see (R3) (R23)
		if (!cascaded_role && cascade_position_list_ff[pend_p.index]) begin
			ack_vector = {vip_pkg::CASC_NIBBLE, pend_p.index}; // see (R6) (R7)
		end
		ret_vector = {bias_nibble_ff, serv_p.index};
		if (!cascaded_role && cascade_position_list_ff[serv_p.index]) begin
			ret_vector = {vip_pkg::CASC_NIBBLE, serv_p.index}; // see (R12)
		end
	end

	// =========================================================
	// AXI write channel, address and data taken in either order
	assign s_awready = !aw_held_ff && !bvalid_ff;
	assign s_wready  = !w_held_ff && !bvalid_ff;
	assign aw_have   = aw_held_ff || (s_awvalid && s_awready);
	assign w_have    = w_held_ff || (s_wvalid && s_wready);
	assign do_write  = aw_have && w_have && !bvalid_ff;
	assign wr_addr   = aw_held_ff ? aw_addr_ff : s_awaddr;
	assign wr_byte   = w_held_ff ? w_byte_ff : s_wdata[7:0];
	assign wr_lane   = w_held_ff ? w_lane_ff : s_wstrb[0];
	assign wr_idx    = wr_addr[6:vip_pkg::ADDR_LSB];
	assign s_bvalid  = bvalid_ff;
	assign s_bresp   = bresp_ff;

	// Hold a half-arrived write until its partner comes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 7'h00;
			w_held_ff  <= 1'b0;
			w_byte_ff  <= 8'h00;
			w_lane_ff  <= 1'b0;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_held_ff <= 1'b1;
				w_byte_ff <= s_wdata[7:0];
				w_lane_ff <= s_wstrb[0];
			end
		end
	end

	// Write response, error for unmapped index
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= vip_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			case (wr_idx)
				vip_pkg::IDX_HW_VECTOR, vip_pkg::IDX_BIAS,
				vip_pkg::IDX_PEND_L, vip_pkg::IDX_PEND_H,
				vip_pkg::IDX_IN_SERVICE_BITS_L, vip_pkg::IDX_IN_SERVICE_BITS_H,
				vip_pkg::IDX_MASK_L, vip_pkg::IDX_MASK_H,
				vip_pkg::IDX_CASC_L, vip_pkg::IDX_CASC_H,
				vip_pkg::IDX_MODE: bresp_ff <= vip_pkg::RESP_OKAY;
				default:           bresp_ff <= vip_pkg::RESP_SLVERR;
			endcase
		end else if (s_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// =========================================================
	// AXI read channel; vector reads are ack or return cycles
	assign s_arready    = !rvalid_ff;
	assign rd_take      = s_arvalid && s_arready;
	assign rd_idx       = s_araddr[6:vip_pkg::ADDR_LSB];
	assign ack_cycle    = rd_take && rd_idx == vip_pkg::IDX_HW_VECTOR
		&& !return_status; // see (R24) (R26)
	assign return_cycle = rd_take && rd_idx == vip_pkg::IDX_HW_VECTOR
		&& return_status; // see (R24) (R26)
	assign s_rvalid     = rvalid_ff;
	assign s_rdata      = {24'h000000, rdata_ff};
	assign s_rresp      = rresp_ff;

	// Read data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 8'h00;
			rresp_ff  <= vip_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= vip_pkg::RESP_OKAY;
			case (rd_idx)
				vip_pkg::IDX_HW_VECTOR:
					rdata_ff <= return_status ? ret_vector : ack_vector;
				vip_pkg::IDX_BIAS:   rdata_ff <= {bias_nibble_ff, 4'h0};
				vip_pkg::IDX_PEND_L: rdata_ff <= pending_bits_ff[7:0];
				vip_pkg::IDX_PEND_H: rdata_ff <= pending_bits_ff[15:8];
				vip_pkg::IDX_IN_SERVICE_BITS_L: rdata_ff <= in_service_bits_ff[7:0];
				vip_pkg::IDX_IN_SERVICE_BITS_H: rdata_ff <= in_service_bits_ff[15:8];
				vip_pkg::IDX_MASK_L: rdata_ff <= position_mask_ff[7:0];
				vip_pkg::IDX_MASK_H: rdata_ff <= position_mask_ff[15:8];
				vip_pkg::IDX_CASC_L: rdata_ff <= cascade_position_list_ff[7:0];
				vip_pkg::IDX_CASC_H: rdata_ff <= cascade_position_list_ff[15:8];
				vip_pkg::IDX_MODE:   rdata_ff <= mode_control_reg_ff;
				default: begin
					rdata_ff <= 8'h00;
					rresp_ff <= vip_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// =========================================================
	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bias_nibble_ff           <= vip_pkg::RST_BIAS;
			position_mask_ff         <= vip_pkg::RST_MASK;
			cascade_position_list_ff <= 16'h0000;
			mode_control_reg_ff      <= vip_pkg::RST_MODE;
		end else if (do_write && wr_lane) begin
			case (wr_idx)
				vip_pkg::IDX_BIAS:   bias_nibble_ff <= wr_byte[7:4];
				vip_pkg::IDX_MASK_L: position_mask_ff[7:0] <= wr_byte;
				vip_pkg::IDX_MASK_H: position_mask_ff[15:8] <= wr_byte;
				vip_pkg::IDX_CASC_L: cascade_position_list_ff[7:0] <= wr_byte;
				vip_pkg::IDX_CASC_H: cascade_position_list_ff[15:8] <= wr_byte;
				vip_pkg::IDX_MODE:   mode_control_reg_ff <= wr_byte;
				default: ;
			endcase
		end
	end

	// =========================================================
	// Pending: software write, ack clear, then hardware set wins
	always_comb begin
		nxt_pending = pending_bits_ff;
		if (do_write && wr_lane && wr_idx == vip_pkg::IDX_PEND_L) begin
			nxt_pending[7:0] = wr_byte; // see (R15)
		end
		if (do_write && wr_lane && wr_idx == vip_pkg::IDX_PEND_H) begin
			nxt_pending[15:8] = wr_byte; // see (R15)
		end
		if (ack_cycle && pend_p.found) begin
			nxt_pending[pend_p.index] = 1'b0; // see (R20)
		end
		if (!freeze_pending) begin
			nxt_pending = nxt_pending | hw_sources; // see (R18)
		end
	end

	// In-service: software write, return clear, ack set
	always_comb begin
		nxt_in_service = in_service_bits_ff;
		if (do_write && wr_lane && wr_idx == vip_pkg::IDX_IN_SERVICE_BITS_L) begin
			nxt_in_service[7:0] = wr_byte;
		end
		if (do_write && wr_lane && wr_idx == vip_pkg::IDX_IN_SERVICE_BITS_H) begin
			nxt_in_service[15:8] = wr_byte;
		end
		if (return_cycle && serv_p.found) begin
			nxt_in_service[serv_p.index] = 1'b0; // see (R13) (R14) (R21)
		end
		if (ack_cycle && pend_p.found) begin
			nxt_in_service[pend_p.index] = 1'b1; // see (R20)
		end
	end

	// Interrupt state and output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending_bits_ff    <= 16'h0000; // see (R1)
			in_service_bits_ff <= 16'h0000;
			irq_n_ff           <= 1'b1; // see (R1)
		end else begin
			pending_bits_ff    <= nxt_pending;
			in_service_bits_ff <= nxt_in_service;
			irq_n_ff           <= !irq_cond;
		end
	end

	assign irq_n = irq_n_ff;

	// =========================================================
	// Checks
	sequence s_ack_read;
		ack_cycle && pend_p.found;
	endsequence

	sequence s_ret_read;
		return_cycle && serv_p.found;
	endsequence

	chk_reset_quiet: assert property (@(posedge aclk) // see (R1)
		!aresetn |=> irq_n)
		else $error("request line active after reset");

	chk_irq_cause: assert property (@(posedge aclk) // see (R16) (R19)
		disable iff (!aresetn)
		!irq_n |-> $past(eligible != 16'h0000 && unit_enable))
		else $error("request without unmasked pending position");

	chk_freeze_hold: assert property (@(posedge aclk) // see (R18)
		disable iff (!aresetn)
		freeze_pending && !do_write |=>
		(pending_bits_ff & ~$past(pending_bits_ff)) == 16'h0000)
		else $error("pending bit set while frozen");

	chk_ack_moves: assert property (@(posedge aclk) // see (R20)
		disable iff (!aresetn)
		s_ack_read ##0 (!do_write && (hw_sources == 16'h0000 ||
		freeze_pending)) |=> !pending_bits_ff[$past(pend_p.index)]
		&& in_service_bits_ff[$past(pend_p.index)])
		else $error("acknowledge did not move position to service");

	chk_ret_clears: assert property (@(posedge aclk) // see (R21)
		disable iff (!aresetn)
		s_ret_read ##0 !do_write |=>
		!in_service_bits_ff[$past(serv_p.index)])
		else $error("return did not end service");

	chk_vector_low: assert property (@(posedge aclk) // see (R3)
		disable iff (!aresetn)
		s_ack_read |=> s_rvalid && s_rdata[3:0] == $past(pend_p.index))
		else $error("vector does not name the position");

	chk_cascade_neg: assert property (@(posedge aclk) // see (R6)
		disable iff (!aresetn)
		s_ack_read ##0 (!cascaded_role &&
		cascade_position_list_ff[pend_p.index]) |=> s_rdata[7]
		&& s_rdata[7:4] == vip_pkg::CASC_NIBBLE)
		else $error("cascaded position not given negative index");

	chk_service_block: assert property (@(posedge aclk) // see (R22)
		disable iff (!aresetn)
		serv_p.found && (!pend_p.found || pend_p.index >= serv_p.index)
		|=> irq_n)
		else $error("request raised below position in service");

	chk_prio_order: assert property (@(posedge aclk) // see (R25)
		disable iff (!aresetn)
		pend_p.found |-> (eligible & ((16'h0001 << pend_p.index)
		- 16'h0001)) == 16'h0000)
		else $error("lower position outranked by higher one");
endmodule : vip_top

// ===== dv/irq_source_model.sv
// Purpose: Interrupting peripherals on the far side of the prioritizer.
// Assumes: Level requests, held as long as the bench asks.
// Notes:   All lines read low while reset is held.
`timescale 1ns/100ps
module irq_source_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] ext_req,
	input  wire logic [15:0] cnt_req,
	output logic      [15:0] ext_irq,
	output logic      [15:0] counter_irq
);
	// Pin and counter outputs, both plain level sources
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_irq     <= 16'h0000;
			counter_irq <= 16'h0000;
		end else begin
			ext_irq     <= ext_req;
			counter_irq <= cnt_req;
		end
	end
endmodule : irq_source_model

// ===== dv/tb.sv
// Purpose: Self-checking bench for the interrupt prioritizer.
// Assumes: Bus answers come when they come; the bench waits.
// Notes:   Read data and write responses checked from queues.
`timescale 1ns/100ps
module tb;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        ret_st, awready, wready, bvalid, arready, rvalid, irq_n;
	logic [6:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [15:0] ext_req, cnt_req, ext_irq, counter_irq;
	logic [33:0] exp_r[$];
	logic [1:0]  exp_b[$];
	logic [7:0]  rnd;
	int          err_count, n_checks, cyc, seed;

	vip_top uut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .return_status(ret_st), .ext_irq(ext_irq),
		.counter_irq(counter_irq), .irq_n(irq_n));
	irq_source_model src (.aclk(aclk), .aresetn(aresetn),
		.ext_req(ext_req), .cnt_req(cnt_req), .ext_irq(ext_irq),
		.counter_irq(counter_irq));

	// ===========================================================
	// Compare and closing tasks
	task automatic cmp_r(input logic [33:0] e, input logic [33:0] s);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED read exp %h seen %h", e, s);
		end
	endtask : cmp_r
	task automatic cmp_b(input logic [1:0] e, input logic [1:0] s);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED bresp exp %h seen %h", e, s);
		end
	endtask : cmp_b
	task automatic cmp_irq(input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED irq_n exp %h seen %h", e, s);
		end
	endtask : cmp_irq
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	// ===========================================================
	// Bus master tasks
	task automatic wr(input logic [4:0] idx, input logic [7:0] d,
		input logic [1:0] resp = vip_pkg::RESP_OKAY);
		logic aw_ok, w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		exp_b.push_back(resp);
		awaddr  <= {idx, 2'h0};
		wdata   <= {24'h000000, d};
		wstrb   <= {3'($random(seed)), 1'h1};
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		do begin
			@(posedge aclk);
			if (!aw_ok && awready) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end while (!(aw_ok && w_ok));
		bready <= 1'h1;
		@(posedge aclk);
		while (!bvalid) @(posedge aclk);
		bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [4:0] idx, input logic st,
		input logic [7:0] d, input logic [1:0] resp = vip_pkg::RESP_OKAY);
		exp_r.push_back({resp, 24'h000000, d});
		araddr  <= {idx, 2'h0};
		ret_st  <= st;
		arvalid <= 1'h1;
		@(posedge aclk);
		while (!arready) @(posedge aclk);
		arvalid <= 1'h0;
		rready  <= 1'h1;
		@(posedge aclk);
		while (!rvalid) @(posedge aclk);
		rready <= 1'h0;
	endtask : rd
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge aclk);
		cmp_irq(e, irq_n);
	endtask : chk_irq

	// Clock
	initial begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	// Response monitor, oldest note first
	always @(posedge aclk) begin
		if (rvalid && rready) cmp_r(exp_r.pop_front(), {rresp, rdata});
		if (bvalid && bready) cmp_b(exp_b.pop_front(), bresp);
	end
	// Hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end

	// ===========================================================
	// Main sequence
	initial begin
		seed = 55020;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, ret_st} = '0;
		{awaddr, araddr, wdata, wstrb, ext_req, cnt_req} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		cmp_irq(1'h1, irq_n);
		rd(vip_pkg::IDX_MASK_L, 1'h0, 8'hff);
		rd(vip_pkg::IDX_MODE, 1'h0, 8'h00);
		rd(vip_pkg::IDX_PEND_L, 1'h0, 8'h00);
		rd(5'h02, 1'h0, 8'h00, vip_pkg::RESP_SLVERR);
		wr(5'h03, 8'hff, vip_pkg::RESP_SLVERR);
		wr(vip_pkg::IDX_BIAS, 8'h5a);
		rd(vip_pkg::IDX_BIAS, 1'h0, 8'h50);
		wr(vip_pkg::IDX_MODE, 8'h02);
		wr(vip_pkg::IDX_PEND_L, 8'h08);
		chk_irq(1'h1);
		wr(vip_pkg::IDX_MASK_L, 8'h00);
		chk_irq(1'h0);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h0, 8'h53);
		chk_irq(1'h1);
		rd(vip_pkg::IDX_PEND_L, 1'h0, 8'h00);
		rd(vip_pkg::IDX_IN_SERVICE_BITS_L, 1'h0, 8'h08);
		wr(vip_pkg::IDX_PEND_L, 8'h20);
		chk_irq(1'h1);
		wr(vip_pkg::IDX_PEND_L, 8'h22);
		chk_irq(1'h0);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h0, 8'h51);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h1, 8'h51);
		rd(vip_pkg::IDX_IN_SERVICE_BITS_L, 1'h0, 8'h08);
		chk_irq(1'h1);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h1, 8'h53);
		chk_irq(1'h0);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h0, 8'h55);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h1, 8'h55);
		// Cascaded position on a pin, position zero left plain
		wr(vip_pkg::IDX_CASC_L, 8'h04);
		ext_req <= 16'h0004;
		repeat (4) @(posedge aclk);
		ext_req <= 16'h0000;
		chk_irq(1'h0);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h0, 8'hf2);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h1, 8'hf2);
		// Freeze against a counter output
		wr(vip_pkg::IDX_MODE, 8'h03);
		cnt_req <= 16'h0010;
		repeat (4) @(posedge aclk);
		rd(vip_pkg::IDX_PEND_L, 1'h0, 8'h00);
		wr(vip_pkg::IDX_MODE, 8'h02);
		rd(vip_pkg::IDX_PEND_L, 1'h0, 8'h10);
		cnt_req <= 16'h0000;
		chk_irq(1'h0);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h0, 8'h54);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h1, 8'h54);
		// Random cascade list byte round trip
		rnd = 8'($random(seed));
		wr(vip_pkg::IDX_CASC_H, rnd);
		rd(vip_pkg::IDX_CASC_H, 1'h0, rnd);
		// Cascaded role: own bias kept, return ends service
		wr(vip_pkg::IDX_MODE, 8'h06);
		wr(vip_pkg::IDX_PEND_L, 8'h04);
		chk_irq(1'h0);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h0, 8'h52);
		rd(vip_pkg::IDX_HW_VECTOR, 1'h1, 8'h52);
		rd(vip_pkg::IDX_IN_SERVICE_BITS_L, 1'h0, 8'h00);
		// Software write removes a pending request
		wr(vip_pkg::IDX_PEND_L, 8'h01);
		wr(vip_pkg::IDX_PEND_L, 8'h00);
		chk_irq(1'h1);
		rd(vip_pkg::IDX_PEND_L, 1'h0, 8'h00);
		repeat (2) @(posedge aclk);
		test_done();
	end
endmodule : tb
